// *** hdl/sat_unit.sv ***
// Single-cycle saturation datapath with sticky saturation flag.
// Assumes the issue logic presents legal widths and never targets stack or program counter.
// Request is read combinationally; result, write strobe and flags leave from flip-flops.
// Illegal widths give an undefined result; the issue side must keep them out.
// Summary of operation
// - Signed word: pre-shift source, clamp to signed n-bit range.
// - Unsigned word: pre-shift, clamp to 0..2^n-1, negatives become 0.
// - In-range values pass through unchanged.
// - Any clamp of a committed request (valid and condition passed) sets the sticky saturation flag to 1.
// - No clamp leaves the sticky flag as it was.
// - Sticky flag clears only by a move-to-special-register write.
// - Sticky flag readable by move-from-special-register.
// - Arithmetic right pre-shift sign-extends by 1 to 31.
// - Logical left pre-shift zero-fills by 0 to 31.
// - Pre-shift optional; without it source saturates unshifted.
// - Negative, zero, carry, overflow flags never changed by saturation; only a move-to-special-register write loads them.
// - Dual signed: each 16-bit lane clamps to signed n-bit independently.
// - Dual unsigned: signed lanes clamp to unsigned n-bit independently.
`timescale 1ns/1ps
`default_nettype none

module sat_unit (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire sat_pkg::sat_req_type  req_i,
    input  wire logic                  status_wr_i,
    input  wire logic                  status_wr_sticky_i,
    input  wire logic [3:0]            nzcv_wr_i,
    output var  sat_pkg::sat_resp_type resp_o,
    output logic                       sticky_o,
    output logic [3:0]                 nzcv_o
);

    // Signed clamp of a 33-bit value to n bits; n is 1..32
    function automatic logic [32:0] clamp_signed(input logic signed [32:0] v,
                                                 input logic [5:0] n);
        logic signed [32:0] hi;
        logic signed [32:0] lo;
        hi = (33'sd1 <<< (n - 6'd1)) - 33'sd1;
        lo = -(33'sd1 <<< (n - 6'd1));
        if (v > hi) begin
            clamp_signed = hi;
        end else if (v < lo) begin
            clamp_signed = lo;
        end else begin
            clamp_signed = v;
        end
    endfunction

    // Unsigned clamp of a 33-bit value to n bits; n is 0..31
    function automatic logic [32:0] clamp_unsigned(input logic signed [32:0] v,
                                                   input logic [5:0] n);
        logic signed [32:0] hi;
        hi = (33'sd1 <<< n) - 33'sd1;
        if (v < 33'sd0) begin
            clamp_unsigned = 33'h0_0000_0000;
        end else if (v > hi) begin
            clamp_unsigned = hi;
        end else begin
            clamp_unsigned = v;
        end
    endfunction

    // Sign extension of one 16-bit lane to the clamp width
    function automatic logic signed [32:0] sext_lane(input logic [15:0] h);
        sext_lane = $signed({{17{h[15]}}, h});
    endfunction

    // Each lane keeps the low half of its clamped value
    function automatic logic [31:0] pack_lanes(input logic [32:0] hi_v,
                                               input logic [32:0] lo_v);
        pack_lanes = {hi_v[15:0], lo_v[15:0]};
    endfunction

    logic signed [32:0] shifted;
    logic [31:0]        lsl_word;
    logic [32:0]        sw_sat;
    logic [32:0]        uw_sat;
    logic [32:0]        sd_hi;
    logic [32:0]        sd_lo;
    logic [32:0]        ud_hi;
    logic [32:0]        ud_lo;
    logic signed [32:0] hi_ext;
    logic signed [32:0] lo_ext;
    logic               sw_clamped;
    logic               uw_clamped;
    logic               sd_clamped;
    logic               ud_clamped;
    logic [31:0]        result_next;
    logic               clamped;
    logic               commit;
    logic               sticky_set;
    logic               sticky_reg;
    logic [3:0]         nzcv_reg;
    logic [31:0]        result_reg;
    logic               wr_reg;

    // Bits shifted past bit 31 are lost before the clamp
    assign lsl_word = req_i.source << req_i.shift_amt;

    // Pre-shift stage; shift is optional
    always_comb begin
        case (req_i.shift_kind)
            sat_pkg::SAT_SHIFT_ASR: begin
                shifted = $signed({req_i.source[31], req_i.source}) >>> req_i.shift_amt;
            end
            sat_pkg::SAT_SHIFT_LSL: begin
                // Left shift wraps within 32 bits, then is read as signed
                shifted = $signed({lsl_word[31], lsl_word});
            end
            default: begin
                shifted = $signed({req_i.source[31], req_i.source});
            end
        endcase
    end

    // Lanes are read as signed halves of the unshifted source
    assign hi_ext = sext_lane(req_i.source[31:16]);
    assign lo_ext = sext_lane(req_i.source[15:0]);

    // All four clamps run in parallel; the operation code only picks one
    always_comb begin
        sw_sat     = clamp_signed(shifted, req_i.width);
        sw_clamped = (sw_sat != shifted);
    end

    always_comb begin
        uw_sat     = clamp_unsigned(shifted, req_i.width);
        uw_clamped = (uw_sat != shifted);
    end

    always_comb begin
        sd_hi      = clamp_signed(hi_ext, req_i.width);
        sd_lo      = clamp_signed(lo_ext, req_i.width);
        sd_clamped = (sd_hi != hi_ext) || (sd_lo != lo_ext);
    end

    always_comb begin
        ud_hi      = clamp_unsigned(hi_ext, req_i.width);
        ud_lo      = clamp_unsigned(lo_ext, req_i.width);
        ud_clamped = (ud_hi != hi_ext) || (ud_lo != lo_ext);
    end

    // Pick the result and clamp flag of the decoded operation
    always_comb begin
        result_next = 32'h0000_0000;
        clamped     = 1'b0;
        case (req_i.op)
            sat_pkg::SAT_OP_SIGNED_WORD: begin
                result_next = sw_sat[31:0];
                clamped     = sw_clamped;
            end
            sat_pkg::SAT_OP_UNSIGNED_WORD: begin
                result_next = uw_sat[31:0];
                clamped     = uw_clamped;
            end
            sat_pkg::SAT_OP_SIGNED_DUAL: begin
                result_next = pack_lanes(sd_hi, sd_lo);
                clamped     = sd_clamped;
            end
            sat_pkg::SAT_OP_UNSIGNED_DUAL: begin
                result_next = pack_lanes(ud_hi, ud_lo);
                clamped     = ud_clamped;
            end
            default: begin
                result_next = 32'h0000_0000;
            end
        endcase
    end

    assign commit = req_i.valid && req_i.cond_pass;

    // A saturation in the same cycle as a software clear wins, so no event is lost
    assign sticky_set = commit && clamped;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sticky_reg <= sat_pkg::STICKY_RESET;
        end else if (sticky_set) begin
            sticky_reg <= 1'b1;
        end else if (status_wr_i) begin
            sticky_reg <= status_wr_sticky_i;
        end else begin
            sticky_reg <= sticky_reg;
        end
    end

    // Condition flags belong to software writes only; saturation never touches them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nzcv_reg <= sat_pkg::NZCV_RESET;
        end else if (status_wr_i) begin
            nzcv_reg <= nzcv_wr_i;
        end
    end

    // Result holds between commits so a late reader still sees it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg <= sat_pkg::RESULT_RESET;
            wr_reg     <= 1'b0;
        end else begin
            wr_reg <= commit;
            if (commit) begin
                result_reg <= result_next;
            end
        end
    end

    assign resp_o.write_en = wr_reg;
    assign resp_o.result   = result_reg;
    assign sticky_o        = sticky_reg;
    assign nzcv_o          = nzcv_reg;

endmodule

`default_nettype wire

// *** hdl/sat_pkg.sv ***
// Package for the saturation datapath: operation codes, shift kinds, carriers.
// Assumes one core clock and the issue logic as the only client.
package sat_pkg;

    localparam int unsigned SAT_WIDTH_BITS = 6;
    localparam int unsigned SHIFT_BITS     = 5;
    localparam logic        STICKY_RESET   = 1'b0;
    localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;
    localparam logic [3:0]  NZCV_RESET     = 4'h0;

    typedef enum logic [1:0] {
        SAT_OP_SIGNED_WORD   = 2'b00,
        SAT_OP_UNSIGNED_WORD = 2'b01,
        SAT_OP_SIGNED_DUAL   = 2'b10,
        SAT_OP_UNSIGNED_DUAL = 2'b11
    } sat_op_type;

    typedef enum logic [1:0] {
        SAT_SHIFT_NONE = 2'b00,
        SAT_SHIFT_ASR  = 2'b01,
        SAT_SHIFT_LSL  = 2'b10
    } sat_shift_type;

    typedef struct packed {
        logic          valid;
        logic          cond_pass;
        sat_op_type    op;
        logic [5:0]    width;
        sat_shift_type shift_kind;
        logic [4:0]    shift_amt;
        logic [31:0]   source;
    } sat_req_type;

    typedef struct packed {
        logic        write_en;
        logic [31:0] result;
    } sat_resp_type;

endpackage

// *** verification/sat_unit_properties.sv ***
// Port checker for the saturation unit.
// Assumes the issue side keeps widths legal; bound to every sat_unit.
`timescale 1ns/1ps
`default_nettype none
module sat_unit_properties (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire sat_pkg::sat_req_type  req_i,
    input wire logic                  status_wr_i,
    input wire logic                  status_wr_sticky_i,
    input wire logic [3:0]            nzcv_wr_i,
    input wire sat_pkg::sat_resp_type resp_o,
    input wire logic                  sticky_o,
    input wire logic [3:0]            nzcv_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire logic take  = req_i.valid & req_i.cond_pass;
    wire logic plain = take & (req_i.shift_kind == 2'h0);
    sequence s_word16;
        plain && req_i.op == 2'h0 && req_i.width == 6'h10;
    endsequence
    sequence s_over16;
        s_word16 ##0 (!req_i.source[31] && |req_i.source[30:15]);
    endsequence
    a_commit_pulse: assert property (take |=> resp_o.write_en)
        else $error("commit gave no write pulse");
    a_refused_quiet: assert property (!take |=> !resp_o.write_en && $stable(resp_o.result))
        else $error("write without commit");
    a_flag_holds: assert property (!take && !status_wr_i |=> $stable(sticky_o))
        else $error("sticky flag moved without cause");
    a_flag_write: assert property (status_wr_i && !take |=> sticky_o == $past(status_wr_sticky_i))
        else $error("status write did not load sticky flag");
    a_flag_no_fall: assert property ($fell(sticky_o) |-> $past(status_wr_i))
        else $error("sticky flag cleared without status write");
    a_nzcv_hold: assert property (!status_wr_i |=> $stable(nzcv_o))
        else $error("condition flags changed");
    a_word_pass: assert property (plain && req_i.op == 2'h0 && req_i.width == 6'h20
        |=> resp_o.result == $past(req_i.source))
        else $error("full width word was altered");
    a_neg_zero: assert property (plain && req_i.op == 2'h1 && req_i.source[31]
        |=> resp_o.result == 32'h0 && sticky_o)
        else $error("negative unsigned not clamped to zero");
    a_sat_max: assert property (s_over16 |=> resp_o.result == 32'h7fff && sticky_o)
        else $error("signed clamp to 16 bits wrong");
endmodule
bind sat_unit sat_unit_properties u_props (.clk_i, .rst_n_i, .req_i, .status_wr_i,
    .status_wr_sticky_i, .nzcv_wr_i, .resp_o, .sticky_o, .nzcv_o);
`default_nettype wire

// *** verification/sat_issue_model.sv ***
// Issue side model: presents saturation requests and status writes.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module sat_issue_model (
    input  wire logic           clk_i,
    output var sat_pkg::sat_req_type req_o,
    output logic                status_wr_o,
    output logic                status_wr_sticky_o,
    output logic [3:0]          nzcv_wr_o
);
    initial begin
        req_o = '0;
        status_wr_o = 1'b0;
        status_wr_sticky_o = 1'b1;
        nzcv_wr_o = 4'h5;
    end
    // Callers keep widths in range; no stack or program counter operands exist here
    task automatic issue(input logic [1:0] op, sh, input logic [5:0] w,
        input logic [4:0] a, input logic [31:0] s, input logic c);
        @(negedge clk_i);
        req_o = '{1'b1, c, sat_pkg::sat_op_type'(op), w, sat_pkg::sat_shift_type'(sh), a, s};
        @(negedge clk_i);
        req_o.valid = 1'b0;
        req_o.source = ~s; // Idle operand is garbage, never the last value
    endtask
    task automatic wr_status(input logic q, input logic [3:0] f);
        @(negedge clk_i);
        {status_wr_o, status_wr_sticky_o, nzcv_wr_o} = {1'b1, q, f};
        @(negedge clk_i);
        {status_wr_o, status_wr_sticky_o, nzcv_wr_o} = {1'b0, ~q, ~f};
    endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the saturation unit.
// Assumes the issue model drives every request input.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    int                    err_total = 0;
    int                    checked = 0;
    sat_pkg::sat_req_type  req;
    sat_pkg::sat_resp_type resp;
    logic                  st_wr, st_q, sticky;
    logic [3:0]            nz_wr, nzcv;
    always #12.5 clk_i = ~clk_i;
    sat_issue_model m (.clk_i, .req_o(req), .status_wr_o(st_wr), .status_wr_sticky_o(st_q),
        .nzcv_wr_o(nz_wr));
    sat_unit dut (.clk_i, .rst_n_i, .req_i(req), .status_wr_i(st_wr), .status_wr_sticky_i(st_q),
        .nzcv_wr_i(nz_wr), .resp_o(resp), .sticky_o(sticky), .nzcv_o(nzcv));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input logic [1:0] op, sh, input logic [5:0] w, input logic [4:0] a,
        input logic [31:0] s, r, input logic q);
        m.issue(op, sh, w, a, s, 1'b1);
        chk("write_en", {31'h0, resp.write_en}, 32'h1);
        chk("result", resp.result, r);
        chk("sticky", {31'h0, sticky}, {31'h0, q});
    endtask
    task automatic clr();
        m.wr_status(1'b0, 4'ha);
        chk("sticky", {31'h0, sticky}, 32'h0);
        chk("nzcv", {28'h0, nzcv}, 32'ha);
    endtask
    task automatic sc_word();
        run(2'h0, 2'h0, 6'h10, 5'h00, 32'h0001_2345, 32'h0000_7fff, 1'b1);
        run(2'h0, 2'h0, 6'h08, 5'h00, 32'hffff_ff80, 32'hffff_ff80, 1'b1);
        clr();
        run(2'h0, 2'h0, 6'h20, 5'h00, 32'h8000_0000, 32'h8000_0000, 1'b0);
        run(2'h0, 2'h0, 6'h08, 5'h00, 32'hffff_ff7f, 32'hffff_ff80, 1'b1);
        clr();
        run(2'h1, 2'h0, 6'h00, 5'h00, 32'h0000_0000, 32'h0000_0000, 1'b0);
        run(2'h1, 2'h0, 6'h1f, 5'h00, 32'h7fff_ffff, 32'h7fff_ffff, 1'b0);
        run(2'h1, 2'h0, 6'h07, 5'h00, 32'hffff_fff0, 32'h0000_0000, 1'b1);
    endtask
    task automatic sc_shift();
        clr();
        run(2'h0, 2'h1, 6'h08, 5'h04, 32'hffff_f800, 32'hffff_ff80, 1'b0);
        run(2'h0, 2'h1, 6'h01, 5'h1f, 32'h8000_0000, 32'hffff_ffff, 1'b0);
        run(2'h0, 2'h2, 6'h10, 5'h00, 32'h0000_7fff, 32'h0000_7fff, 1'b0);
        run(2'h0, 2'h2, 6'h10, 5'h04, 32'h0000_0800, 32'h0000_7fff, 1'b1);
    endtask
    task automatic sc_dual();
        clr();
        run(2'h2, 2'h0, 6'h10, 5'h00, 32'h8000_7fff, 32'h8000_7fff, 1'b0);
        run(2'h2, 2'h0, 6'h09, 5'h00, 32'h0100_ff00, 32'h00ff_ff00, 1'b1);
        clr();
        run(2'h3, 2'h0, 6'h0d, 5'h00, 32'h8000_1234, 32'h0000_1234, 1'b1);
    endtask
    task automatic sc_refused();
        clr();
        m.issue(2'h0, 2'h0, 6'h10, 5'h00, 32'h0001_2345, 1'b0);
        chk("write_en", {31'h0, resp.write_en}, 32'h0);
        chk("result", resp.result, 32'h0000_1234);
        chk("sticky", {31'h0, sticky}, 32'h0);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        sc_word();
        sc_shift();
        sc_dual();
        sc_refused();
        final_report();
    end
endmodule
`default_nettype wire
